//--- phy_diag_pkg.sv
// Constants and types for the PHY diagnostic, status and event registers
package phy_diag_pkg;

	// Register offsets, as printed
	localparam logic [15:0] OFF_CABLE_DIAG = 16'h0124;
	localparam logic [15:0] OFF_LINK_STATE = 16'h0126;
	localparam logic [15:0] OFF_SYM_ERR_CNT = 16'h012a;
	localparam logic [15:0] OFF_EVENT = 16'h0136;

	// Smallest address width that still holds every offset
	localparam int unsigned ADDR_W_MIN = 9;
	localparam int unsigned DATA_W = 16;

	// Cable diagnostic register fields
	localparam int unsigned DIAG_START_BIT = 15;
	localparam int unsigned DIAG_RSV_HI_BIT = 14;
	localparam int unsigned DIAG_PAIR_MSB = 13;
	localparam int unsigned DIAG_PAIR_LSB = 12;
	localparam int unsigned DIAG_RSV_MSB = 11;
	localparam int unsigned DIAG_RSV_LSB = 10;
	localparam int unsigned DIAG_OUT_MSB = 9;
	localparam int unsigned DIAG_OUT_LSB = 8;
	localparam int unsigned DIAG_DIST_MSB = 7;
	localparam int unsigned DIAG_DIST_LSB = 0;

	// Link state register fields
	localparam int unsigned LINK_GIG_BIT = 1;
	localparam int unsigned LINK_FAST_BIT = 0;

	// Event register fields
	localparam int unsigned EN_MSB = 15;
	localparam int unsigned EN_LSB = 8;
	localparam int unsigned FLAG_MSB = 7;
	localparam int unsigned FLAG_LSB = 0;
	localparam int unsigned EVT_NUM = 8;

	// Event positions inside the flag and enable bytes
	localparam int unsigned EVT_JABBER = 7;
	localparam int unsigned EVT_RX_ERROR = 6;
	localparam int unsigned EVT_PAGE_RX = 5;
	localparam int unsigned EVT_PAR_DET_FAULT = 4;
	localparam int unsigned EVT_PARTNER_ACK = 3;
	localparam int unsigned EVT_LINK_DOWN = 2;
	localparam int unsigned EVT_REMOTE_FAULT = 1;
	localparam int unsigned EVT_LINK_UP = 0;

	// Reset values
	localparam logic [1:0] PAIR_RST = 2'h0;
	localparam logic [1:0] RSV2_RST = 2'h0;
	localparam logic [1:0] OUTCOME_RST = 2'h0;
	localparam logic [7:0] DIST_RST = 8'h00;
	localparam logic [7:0] EN_RST = 8'h00;
	localparam logic [7:0] FLAG_RST = 8'h00;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] RDATA_IDLE = 16'h0000;

	// Cable test outcome codes
	typedef enum logic [1:0] {
		OUTCOME_NORMAL = 2'h0,
		OUTCOME_OPEN = 2'h1,
		OUTCOME_SHORT = 2'h2,
		OUTCOME_FAILED = 2'h3
	} diag_outcome_t;

	// Pair select codes
	typedef enum logic [1:0] {
		PAIR_A = 2'h0,
		PAIR_B = 2'h1,
		PAIR_C = 2'h2,
		PAIR_D = 2'h3
	} diag_pair_t;

endpackage : phy_diag_pkg

//--- phy_diag_status_irq_regs.sv
// Per-port cable diagnostic, link state, error count and event registers
//
// Contract
// - Writing one to bit 15 starts a cable test; self-clears at completion; zero stops.
// - Bit 15 reads one while testing, zero once results are valid.
// - Bits 13:12 select pair A to D; reset value 00.
// - Bits 9:8 report normal, open, short or failed outcome; read-only.
// - Bits 7:0 give fault distance for open or short; read-only.
// - Link state bit 1 shows gigabit link up, bit 0 shows 100 Mb/s.
// - 16-bit count of frames with symbol errors; resets zero, clears on read.
// - Bits 15:8 are read/write event enables, reset zero, jabber down to link up.
// - Bit 7 flags jabber; read-only, resets zero, cleared by reading.
// - Bit 6 flags receive error; read-only, cleared by reading.
// - Bit 5 flags auto-negotiation page received; cleared by reading.
// - Bit 4 flags parallel detection fault; cleared by reading.
// - Bit 3 flags link partner acknowledge; cleared by reading.
// - Bit 2 flags link down; cleared by reading.
// - Bit 1 flags remote fault; cleared by reading.
// - Bit 0 flags link up; cleared by reading.
`timescale 1ns/1ns
module phy_diag_status_irq_regs #(
	parameter int unsigned ADDR_W = 12,
	parameter int unsigned CNT_W = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [phy_diag_pkg::DATA_W-1:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	output logic [phy_diag_pkg::DATA_W-1:0] rd_data_o,
	// Cable test engine
	output logic diag_start_o,
	output logic diag_abort_o,
	output logic [1:0] diag_pair_o,
	input wire logic diag_done_i,
	input wire logic [1:0] diag_outcome_i,
	input wire logic [7:0] diag_distance_i,
	// Link state
	input wire logic gig_link_up_i,
	input wire logic fast_link_up_i,
	// Receive frame with symbol error
	input wire logic receive_symbol_error_i,
	// Event pulses, same order as the flag byte
	input wire logic [phy_diag_pkg::EVT_NUM-1:0] event_i,
	// Interrupt request
	output logic irq_o
);
	import phy_diag_pkg::*;

	typedef enum logic {
		DIAG_IDLE,
		DIAG_RUNNING
	} diag_state_t;

	// Elaboration checks: the decoder slices offsets, the counter pads
	if (ADDR_W < ADDR_W_MIN || ADDR_W > DATA_W)
	begin : g_bad_addr_w
		$error("ADDR_W out of range");
	end
	if (CNT_W < 1 || CNT_W > DATA_W)
	begin : g_bad_cnt_w
		$error("CNT_W out of range");
	end
	if (EVT_NUM != EN_MSB - EN_LSB + 1 ||
		EVT_NUM != FLAG_MSB - FLAG_LSB + 1)
	begin : g_bad_evt_num
		$error("event count does not fill the enable and flag bytes");
	end
	if (DIAG_PAIR_MSB - DIAG_PAIR_LSB + 1 != $bits(diag_pair_o))
	begin : g_bad_pair_w
		$error("pair field and engine port differ in width");
	end

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [15:0] off);
		hit = (a == off[ADDR_W-1:0]);
	endfunction : hit

	// Register selected by an address
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_DIAG,
		SEL_LINK,
		SEL_CNT,
		SEL_EVENT
	} reg_sel_t;

	// One decoder for the write side and the read side; offsets are
	// compared on the low ADDR_W bits only
	function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
		if (hit(a, OFF_CABLE_DIAG))
			decode = SEL_DIAG;
		else if (hit(a, OFF_LINK_STATE))
			decode = SEL_LINK;
		else if (hit(a, OFF_SYM_ERR_CNT))
			decode = SEL_CNT;
		else if (hit(a, OFF_EVENT))
			decode = SEL_EVENT;
		else
			decode = SEL_NONE;
	endfunction : decode

	// Cable test state and fields
	diag_state_t diag_state_reg;
	diag_state_t diag_state_next;
	logic diag_running;
	logic diag_launch;
	logic diag_stop;
	logic done_take;
	logic [1:0] pair_reg;
	logic rsv14_reg;
	logic [1:0] rsv2_reg;
	logic [1:0] outcome_reg;
	logic [7:0] dist_reg;
	logic diag_start_reg;
	logic diag_abort_reg;

	// Link state and error count
	logic gig_link_reg;
	logic fast_link_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;

	// Event enables, flags and request
	logic [EVT_NUM-1:0] en_reg;
	logic [EVT_NUM-1:0] flag_reg;
	logic [EVT_NUM-1:0] flag_next;
	logic [EVT_NUM-1:0] en_next;
	logic irq_reg;
	logic irq_next;

	// Register port decode and read word
	reg_sel_t sel;
	logic wr_diag;
	logic wr_event;
	logic rd_cnt;
	logic rd_event;
	logic [DATA_W-1:0] rd_data_reg;
	logic [DATA_W-1:0] rd_data_next;

	assign sel = decode(addr_i);
	assign wr_diag = wr_en_i && (sel == SEL_DIAG);
	assign wr_event = wr_en_i && (sel == SEL_EVENT);
	assign rd_cnt = rd_en_i && (sel == SEL_CNT);
	assign rd_event = rd_en_i && (sel == SEL_EVENT);

	// Start and stop requests carried by a write of the start bit
	assign diag_running = (diag_state_reg == DIAG_RUNNING);
	assign diag_launch = wr_diag && wr_data_i[DIAG_START_BIT];
	assign diag_stop = wr_diag && !wr_data_i[DIAG_START_BIT];

	// A completion beside a write of this register is ignored
	assign done_take = diag_running && diag_done_i && !wr_diag;

	always_comb
	begin
		diag_state_next = diag_state_reg;
		unique case (diag_state_reg)
			DIAG_IDLE:
			begin
				if (diag_launch)
					diag_state_next = DIAG_RUNNING;
			end
			DIAG_RUNNING:
			begin
				// Software stop overrides a completion in the same cycle
				if (diag_stop)
					diag_state_next = DIAG_IDLE;
				else if (done_take)
					diag_state_next = DIAG_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			diag_state_reg <= DIAG_IDLE;
		else
			diag_state_reg <= diag_state_next;
	end

	// engine start strobe on entry to a test
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			diag_start_reg <= 1'b0;
		else
			diag_start_reg <= (diag_state_reg == DIAG_IDLE) &&
				diag_launch;
	end

	// engine abort strobe when software stops a running test
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			diag_abort_reg <= 1'b0;
		else
			diag_abort_reg <= diag_running &&
				diag_stop;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			pair_reg <= PAIR_RST;
		else if (wr_diag)
			pair_reg <= wr_data_i[DIAG_PAIR_MSB:DIAG_PAIR_LSB];
	end

	// Reserved bits are kept so software reads back what it wrote
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			rsv14_reg <= 1'b0;
			rsv2_reg <= RSV2_RST;
		end
		else if (wr_diag)
		begin
			rsv14_reg <= wr_data_i[DIAG_RSV_HI_BIT];
			rsv2_reg <= wr_data_i[DIAG_RSV_MSB:DIAG_RSV_LSB];
		end
	end

	// outcome latches only on an accepted completion
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			outcome_reg <= OUTCOME_RST;
		else if (done_take)
			outcome_reg <= diag_outcome_i;
	end

	// distance taken with the outcome, whatever its meaning
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			dist_reg <= DIST_RST;
		else if (done_take)
			dist_reg <= diag_distance_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			gig_link_reg <= 1'b0;
		else
			gig_link_reg <= gig_link_up_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			fast_link_reg <= 1'b0;
		else
			fast_link_reg <= fast_link_up_i;
	end

	// count and clear on read; a frame in the read cycle survives
	always_comb
	begin
		cnt_next = cnt_reg;
		if (rd_cnt)
			cnt_next = CNT_W'(receive_symbol_error_i);
		else if (receive_symbol_error_i && !(&cnt_reg))
			cnt_next = cnt_reg + 1'b1;
	end

	// Saturates rather than wrapping, so a full count is never lost
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			cnt_reg <= CNT_RST[CNT_W-1:0];
		else
			cnt_reg <= cnt_next;
	end

	// enables
	// Writes to the flag byte are dropped; flags clear only on a read
	assign en_next = wr_event ? wr_data_i[EN_MSB:EN_LSB] : en_reg;

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			en_reg <= EN_RST;
		else
			en_reg <= en_next;
	end

	// event flags, jabber down to link up
	// A pulse in the read cycle sets the flag again, so it is not lost
	// Events are one-cycle pulses on this clock
	for (genvar i = 0; i < EVT_NUM; i++)
	begin : g_flag
		assign flag_next[i] = event_i[i] | (flag_reg[i] & ~rd_event);

		always_ff @(posedge clk_i)
		begin
			if (!rst_n_i)
				flag_reg[i] <= FLAG_RST[i];
			else
				flag_reg[i] <= flag_next[i];
		end
	end

	// enabled flags raise the request
	// Next-state terms put the request on the same edge as its flag
	assign irq_next = |(flag_next & en_next);

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			irq_reg <= 1'b0;
		else
			irq_reg <= irq_next;
	end

	// start bit shows the test in progress
	always_comb
	begin
		rd_data_next = RDATA_IDLE;
		if (rd_en_i)
		begin
			unique case (sel)
				SEL_DIAG:
					rd_data_next = {diag_running, rsv14_reg, pair_reg,
						rsv2_reg, outcome_reg, dist_reg};
				SEL_LINK:
					rd_data_next = {{(DATA_W-2){1'b0}}, gig_link_reg,
						fast_link_reg};
				SEL_CNT:
					rd_data_next = DATA_W'(cnt_reg);
				SEL_EVENT:
					rd_data_next = {en_reg, flag_reg};
				SEL_NONE:
					rd_data_next = RDATA_IDLE;
			endcase
		end
	end

	// Idle reads return zero, so a stale word is never taken for data
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			rd_data_reg <= RDATA_IDLE;
		else
			rd_data_reg <= rd_data_next;
	end

	// Every output is a register; nothing combinational leaves the block
	assign rd_data_o = rd_data_reg;
	assign diag_start_o = diag_start_reg;
	assign diag_abort_o = diag_abort_reg;
	assign diag_pair_o = pair_reg;
	assign irq_o = irq_reg;

endmodule : phy_diag_status_irq_regs

//--- phy_diag_chk_assertions.sv
// Assertions for the PHY diagnostic, link and event register block
`timescale 1ns/1ns
module phy_diag_chk #(
	parameter int unsigned ADDR_W = 12
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [phy_diag_pkg::DATA_W-1:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [phy_diag_pkg::DATA_W-1:0] rd_data_o,
	// Block side
	input wire logic diag_start_o,
	input wire logic diag_abort_o,
	input wire logic [1:0] diag_pair_o,
	input wire logic gig_link_up_i,
	input wire logic fast_link_up_i,
	input wire logic receive_symbol_error_i,
	input wire logic [phy_diag_pkg::EVT_NUM-1:0] event_i,
	input wire logic irq_o
);
	import phy_diag_pkg::*;
	wire logic dg = addr_i == ADDR_W'(OFF_CABLE_DIAG);
	wire logic cn = addr_i == ADDR_W'(OFF_SYM_ERR_CNT);
	wire logic ev = addr_i == ADDR_W'(OFF_EVENT);
	wire logic lk = addr_i == ADDR_W'(OFF_LINK_STATE);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	property p_start;
		diag_start_o |-> $past(wr_en_i && dg && wr_data_i[15]);
	endproperty
	a_start: assert property (p_start) else $error("stray start");
	property p_abort;
		diag_abort_o |-> $past(wr_en_i && dg && !wr_data_i[15]);
	endproperty
	a_abort: assert property (p_abort) else $error("stray abort");
	property p_pair;
		$past(wr_en_i && dg) |-> diag_pair_o == $past(wr_data_i[13:12]);
	endproperty
	a_pair: assert property (p_pair) else $error("pair not taken");
	property p_link;
		rd_en_i && lk |=> rd_data_o ==
			{14'h0000, $past(gig_link_up_i, 2), $past(fast_link_up_i, 2)};
	endproperty
	a_link: assert property (p_link) else $error("link state");
	property p_cnt;
		rd_en_i && cn && !receive_symbol_error_i ##1 rd_en_i && cn
			|=> rd_data_o == 16'h0000;
	endproperty
	a_cnt: assert property (p_cnt) else $error("count kept");
	property p_flag;
		rd_en_i && ev && event_i == 8'h00 ##1 rd_en_i && ev
			|=> rd_data_o[7:0] == 8'h00;
	endproperty
	a_flag: assert property (p_flag) else $error("flags kept");
	property p_irq_up;
		$rose(irq_o) |-> $past(|event_i || wr_en_i) || $past(wr_en_i, 2);
	endproperty
	a_irq_up: assert property (p_irq_up) else $error("irq rise");
	property p_irq_dn;
		$fell(irq_o) |-> $past(rd_en_i || wr_en_i) || $past(rd_en_i, 2);
	endproperty
	a_irq_dn: assert property (p_irq_dn) else $error("irq fall");
	property p_idle;
		!$past(rd_en_i) |-> rd_data_o == 16'h0000;
	endproperty
	a_idle: assert property (p_idle) else $error("read data idle");
endmodule : phy_diag_chk

bind phy_diag_status_irq_regs phy_diag_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

//--- testbench.sv
// Self-checking bench for the PHY diagnostic, link and event registers
`timescale 1ns/1ns
module testbench;
	import phy_diag_pkg::*;
	logic clk_i, rst_n_i, wr_en_i, rd_en_i, diag_done_i, irq_o;
	logic gig_link_up_i, fast_link_up_i, receive_symbol_error_i;
	logic diag_start_o, diag_abort_o;
	logic [11:0] addr_i;
	logic [15:0] wr_data_i, rd_data_o;
	logic [1:0] diag_pair_o, diag_outcome_i;
	logic [7:0] diag_distance_i, event_i;
	int n_errors = 0;
	int samples_checked = 0;
	int i;
	phy_diag_status_irq_regs u_dut (.*);
	initial
	begin
		clk_i = 0;
		forever #4 clk_i = ~clk_i;
	end
	task summarize;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [11:0] a, input logic [15:0] d);
		addr_i <= a;
		wr_data_i <= d;
		wr_en_i <= 1;
		@(posedge clk_i);
		wr_en_i <= 0;
		#1;
	endtask : wr
	task rd(input logic [11:0] a, input logic [15:0] e);
		addr_i <= a;
		rd_en_i <= 1;
		@(posedge clk_i);
		rd_en_i <= 0;
		#1 chk(rd_data_o, e);
	endtask : rd
	task done(input logic [1:0] o, input logic [7:0] d);
		diag_outcome_i <= o;
		diag_distance_i <= d;
		diag_done_i <= 1;
		@(posedge clk_i);
		diag_done_i <= 0;
		diag_outcome_i <= ~o;
		diag_distance_i <= ~d;
		#1;
	endtask : done
	task evt(input logic [7:0] v);
		event_i <= v;
		@(posedge clk_i);
		event_i <= 0;
		#1;
	endtask : evt
	task cyc;
		@(posedge clk_i);
		#1;
	endtask : cyc
	task t_reset;
		rd(12'h124, 16'h0000);
		rd(12'h12a, 16'h0000);
		rd(12'h136, 16'h0000);
		rd(12'h130, 16'h0000);
		$display("reset values done");
	endtask : t_reset
	task t_diag;
		wr(12'h124, 16'h9000);
		chk(diag_start_o, 16'h0001);
		chk(diag_pair_o, 16'h0001);
		rd(12'h124, 16'h9000);
		done(OUTCOME_OPEN, 8'h2a);
		rd(12'h124, 16'h112a);
		wr(12'h124, 16'hb000);
		rd(12'h124, 16'hb12a);
		wr(12'h124, 16'h3000);
		chk(diag_abort_o, 16'h0001);
		rd(12'h124, 16'h312a);
		for (i = 0; i < 4; i++)
		begin
			wr(12'h124, 16'h8000);
			done(i[1:0], 8'h40 + i[7:0]);
			rd(12'h124, {6'h00, i[1:0], 8'h40 + i[7:0]});
		end
		done(OUTCOME_SHORT, 8'h99);
		rd(12'h124, 16'h0343);
		$display("cable test done");
	endtask : t_diag
	task t_link;
		for (i = 0; i < 4; i++)
		begin
			{gig_link_up_i, fast_link_up_i} <= i[1:0];
			cyc;
			cyc;
			rd(12'h126, {14'h0000, i[1:0]});
		end
		$display("link state done");
	endtask : t_link
	task t_cnt;
		wr(12'h12a, 16'h1234);
		repeat (3)
		begin
			receive_symbol_error_i <= 1;
			@(posedge clk_i);
			receive_symbol_error_i <= 0;
			cyc;
		end
		rd(12'h12a, 16'h0003);
		rd(12'h12a, 16'h0000);
		receive_symbol_error_i <= 1;
		rd(12'h12a, 16'h0000);
		receive_symbol_error_i <= 0;
		rd(12'h12a, 16'h0001);
		$display("error count done");
	endtask : t_cnt
	task t_evt;
		for (i = 0; i < 8; i++)
		begin
			evt(8'h01 << i);
			chk(irq_o, 16'h0000);
			rd(12'h136, 16'h0001 << i);
			rd(12'h136, 16'h0000);
		end
		wr(12'h136, 16'hffff);
		rd(12'h136, 16'hff00);
		evt(8'h80);
		chk(irq_o, 16'h0001);
		wr(12'h136, 16'h7f00);
		cyc;
		chk(irq_o, 16'h0000);
		wr(12'h136, 16'hff00);
		cyc;
		chk(irq_o, 16'h0001);
		rd(12'h136, 16'hff80);
		cyc;
		chk(irq_o, 16'h0000);
		event_i <= 8'h04;
		rd(12'h136, 16'hff00);
		event_i <= 8'h00;
		chk(irq_o, 16'h0001);
		rd(12'h136, 16'hff04);
		cyc;
		chk(irq_o, 16'h0000);
		$display("events done");
	endtask : t_evt
	initial
	begin
		rst_n_i = 0;
		{wr_en_i, rd_en_i, diag_done_i, receive_symbol_error_i} = '0;
		{gig_link_up_i, fast_link_up_i} = '0;
		addr_i = 0;
		wr_data_i = 0;
		diag_outcome_i = 0;
		diag_distance_i = 0;
		event_i = 0;
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1;
		cyc;
		t_reset;
		t_diag;
		t_link;
		t_cnt;
		t_evt;
		summarize;
	end
	// Guard against a hung run
	initial
	begin
		#200000;
		n_errors++;
		summarize;
	end
endmodule : testbench
